// [include/mia_pkg.sv]
// shared constants and helpers for the indirect extended register access block
package mia_pkg;

  // register indices (byte address = index * 4)
  localparam logic [7:0]  IDX_CTRL      = 8'h0d;
  localparam logic [7:0]  IDX_WINDOW    = 8'h0e;
  localparam logic [7:0]  IDX_LINK_DROP = 8'h0f;

  // control register fields
  localparam int unsigned CMD_MSB       = 15;
  localparam int unsigned CMD_LSB       = 14;
  localparam int unsigned SEL_MSB       = 4;
  localparam int unsigned SEL_LSB       = 0;

  // reset values
  localparam logic [1:0]  CMD_RST       = 2'h0;
  localparam logic [4:0]  SEL_RST       = 5'h00;
  localparam logic [15:0] WINDOW_RST    = 16'h0000;

  // target space select codes
  localparam logic [4:0]  SEL_VENDOR    = 5'h1f;
  localparam logic [4:0]  SEL_MMD3      = 5'h03;
  localparam logic [4:0]  SEL_MMD7      = 5'h07;
  localparam logic [15:0] VENDOR_LAST   = 16'h04d1;

  typedef enum logic [1:0] {
    CMD_ADDRESS = 2'h0,
    CMD_DATA    = 2'h1,
    CMD_INC_RW  = 2'h2,
    CMD_INC_WR  = 2'h3
  } mia_cmd_e;

  typedef enum logic [1:0] {
    SP_VENDOR = 2'h0,
    SP_MMD3   = 2'h1,
    SP_MMD7   = 2'h2
  } mia_space_e;

  // space index for a target select value; vendor when unsupported
  function automatic mia_space_e space_of(input logic [4:0] sel);
    case (sel)
      SEL_MMD3: space_of = SP_MMD3;
      SEL_MMD7: space_of = SP_MMD7;
      default:  space_of = SP_VENDOR;
    endcase
  endfunction

  function automatic logic space_ok(input logic [4:0] sel);
    space_ok = (sel == SEL_VENDOR) || (sel == SEL_MMD3) || (sel == SEL_MMD7);
  endfunction

  // apply the two low byte strobes to a 16-bit value
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    lane_merge[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
    lane_merge[7:0]  = strb[0] ? new_v[7:0]  : old_v[7:0];
  endfunction

endpackage

// [core/mia_ext_mem.sv]
// extended register storage for the three target spaces
`timescale 1ns/1ps
`default_nettype none
module mia_ext_mem #(
  parameter int unsigned DW = 16,
  parameter int unsigned AW = 13
) (
  input  wire logic          pclk,    // clock
  input  wire logic          pce,     // clock enable
  input  wire logic          rd_en,   // read strobe
  input  wire logic          wr_en,   // write strobe
  input  wire logic [AW-1:0] addr,    // word address
  input  wire logic [DW-1:0] wdata,   // write data
  output logic      [DW-1:0] rdata    // registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (pce && wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (pce && rd_en) begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// [core/mia_indirect_access.sv]
// indirect access control and window registers with apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
//
// Summary of operation
// - command 0: window reads and writes the selected space's address register
// - command 1: window moves data, stored address stays unchanged
// - command 2: window moves data, address increments after each read and write
// - command 3: window moves data, address increments only after writes
// - target select bits 4-0 choose the space reached through the window
// - select 11111 reaches vendor space, addresses up to 0x04d1
// - select 00011 reaches the mmd3 space
// - select 00111 reaches the mmd7 space
// - window transactions under any other select value are ignored
// - nonzero command: window is the data port at the stored address
//
module mia_indirect_access
  import mia_pkg::*;
#(
  parameter int unsigned PADDR_W = 8,
  parameter int unsigned EXT_AW  = 11
) (
  input  wire logic               pclk,     // apb clock
  input  wire logic               presetn,  // async reset, low active
  input  wire logic               pce,      // clock enable
  input  wire logic               psel,     // apb select
  input  wire logic               penable,  // apb enable
  input  wire logic               pwrite,   // apb direction
  input  wire logic [PADDR_W-1:0] paddr,    // apb byte address
  input  wire logic [31:0]        pwdata,   // apb write data
  input  wire logic [3:0]         pstrb,    // apb byte strobes
  output logic      [31:0]        prdata,   // apb read data
  output logic                    pready,   // apb ready
  output logic                    pslverr   // apb error
);

  localparam logic [PADDR_W-1:0] A_CTRL   = PADDR_W'({IDX_CTRL, 2'b00});
  localparam logic [PADDR_W-1:0] A_WINDOW = PADDR_W'({IDX_WINDOW, 2'b00});
  localparam logic [PADDR_W-1:0] A_DROP   = PADDR_W'({IDX_LINK_DROP, 2'b00});
  localparam int unsigned        MEM_AW   = EXT_AW + 2;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} mia_state_e;

  mia_state_e         state;
  mia_cmd_e           cmd;
  logic [4:0]         sel;
  logic [15:0]        ext_addr [0:2];
  logic [15:0]        cur_addr;
  logic [15:0]        mem_rdata;
  logic [15:0]        mem_wdata;
  logic [MEM_AW-1:0]  mem_addr;
  mia_space_e         sp;
  logic               sp_valid;
  logic               ext_ok;
  logic               data_mode;
  logic               hit_ctrl;
  logic               hit_win;
  logic               hit_drop;
  logic               setup;
  logic               done;
  logic               mem_rd;
  logic               mem_wr;
  logic [31:0]        next_prdata;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign setup     = psel && !penable;
  assign done      = (state == ST_DONE) && psel && penable;
  assign hit_ctrl  = (paddr == A_CTRL);
  assign hit_win   = (paddr == A_WINDOW);
  assign hit_drop  = (paddr == A_DROP);
  assign data_mode = (cmd != CMD_ADDRESS);
  assign sp        = space_of(sel);
  assign sp_valid  = space_ok(sel);
  assign cur_addr  = ext_addr[sp];

  // vendor space ends at its last address, others at the storage size
  always_comb begin
    ext_ok = sp_valid && ((cur_addr >> EXT_AW) == 16'h0000);
    if (sp == SP_VENDOR && cur_addr > VENDOR_LAST) begin
      ext_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // extended storage

  assign mem_addr  = {sp, cur_addr[EXT_AW-1:0]};
  assign mem_rd    = (state == ST_IDLE) && setup && hit_win && data_mode && ext_ok;
  assign mem_wr    = done && pwrite && hit_win && data_mode && ext_ok;
  assign mem_wdata = lane_merge(mem_rdata, pwdata, pstrb);

  mia_ext_mem #(
    .DW (16),
    .AW (MEM_AW)
  ) u_mem (
    .pclk  (pclk),
    .pce   (pce),
    .rd_en (mem_rd),
    .wr_en (mem_wr),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb sequencing: setup, fetch, ready

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (pce) begin
      case (state)
        ST_IDLE: begin
          if (setup) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: state <= ST_DONE;
        ST_DONE: begin
          if (!psel || penable) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata[CMD_MSB:CMD_LSB] = cmd;
      next_prdata[SEL_MSB:SEL_LSB] = sel;
    end else if (hit_win && !data_mode && sp_valid) begin
      next_prdata[15:0] = cur_addr;
    end else if (hit_win && data_mode && ext_ok) begin
      next_prdata[15:0] = mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (pce) begin
      pready  <= (state == ST_FETCH);
      pslverr <= (state == ST_FETCH) && !(hit_ctrl || hit_win || hit_drop);
      if (state == ST_FETCH) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= CMD_ADDRESS;
      sel <= SEL_RST;
    end else if (pce && done && pwrite && hit_ctrl) begin
      if (pstrb[1]) begin
        cmd <= mia_cmd_e'(pwdata[CMD_MSB:CMD_LSB]);
      end
      if (pstrb[0]) begin
        sel <= pwdata[SEL_MSB:SEL_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored extended addresses, one per space

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        ext_addr[i] <= WINDOW_RST;
      end
    end else if (pce && done && hit_win && sp_valid) begin
      case (cmd)
        CMD_ADDRESS: begin
          if (pwrite) begin
            ext_addr[sp] <= lane_merge(cur_addr, pwdata, pstrb);
          end
        end
        CMD_DATA: ext_addr[sp] <= cur_addr;
        CMD_INC_RW: ext_addr[sp] <= cur_addr + 16'h0001;
        CMD_INC_WR: begin
          if (pwrite) begin
            ext_addr[sp] <= cur_addr + 16'h0001;
          end
        end
        default: ext_addr[sp] <= cur_addr;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_fetch_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_FETCH && pce) |=> pready && !$past(pready))
    else $error("ready did not follow fetch");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && pce) |=> !pready)
    else $error("ready held longer than one cycle");

  a_ctrl_cmd_write: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && done && pwrite && hit_ctrl && pstrb[1])
      |=> cmd == $past(pwdata[CMD_MSB:CMD_LSB]))
    else $error("command field not written");

  a_addr_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && done && pwrite && hit_win && cmd == CMD_ADDRESS && sp_valid
      && pstrb[1:0] == 2'b11)
      |=> cur_addr == $past(pwdata[15:0]))
    else $error("address not captured through window");

  a_no_increment: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && done && hit_win && cmd == CMD_DATA)
      |=> cur_addr == $past(cur_addr))
    else $error("address moved under plain data command");

  a_inc_read_write: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && done && hit_win && cmd == CMD_INC_RW && sp_valid)
      |=> cur_addr == $past(cur_addr) + 16'h0001)
    else $error("address not incremented after access");

  a_inc_write_only: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && done && hit_win && cmd == CMD_INC_WR && sp_valid)
      |=> cur_addr == ($past(pwrite) ? $past(cur_addr) + 16'h0001 : $past(cur_addr)))
    else $error("write-only increment misbehaved");

  a_space_select: assert property (@(posedge pclk) disable iff (!presetn)
    mem_wr |-> mem_addr[MEM_AW-1:EXT_AW] == sp && sp_valid)
    else $error("write routed to wrong space");

  a_vendor_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == SEL_VENDOR && cur_addr > VENDOR_LAST) |-> !mem_wr && !mem_rd)
    else $error("vendor access beyond last address");

  a_mmd_routes: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == SEL_MMD3) |-> sp == SP_MMD3 && sp_valid)
    else $error("mmd3 select misrouted");

  a_mmd7_route: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == SEL_MMD7) |-> sp == SP_MMD7 && sp_valid)
    else $error("mmd7 select misrouted");

  a_bad_space_read: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && state == ST_FETCH && hit_win && !sp_valid) |=> prdata == 32'h0000_0000)
    else $error("ignored space returned data");

  a_bad_space_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && done && hit_win && !sp_valid)
      |=> ext_addr[0] == $past(ext_addr[0]) && ext_addr[1] == $past(ext_addr[1])
        && ext_addr[2] == $past(ext_addr[2]) && !$past(mem_wr))
    else $error("ignored space changed state");

  a_data_read: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && state == ST_FETCH && !pwrite && hit_win && data_mode && ext_ok)
      |=> prdata[15:0] == $past(mem_rdata))
    else $error("window read did not return stored data");

  c_ctrl_write: cover property (@(posedge pclk) disable iff (!presetn)
    pce && done && pwrite && hit_ctrl);

  c_inc_read: cover property (@(posedge pclk) disable iff (!presetn)
    pce && done && !pwrite && hit_win && cmd == CMD_INC_RW && ext_ok);

  c_bad_space: cover property (@(posedge pclk) disable iff (!presetn)
    pce && done && hit_win && !sp_valid);

  c_slave_error: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);

endmodule
`default_nettype wire

// [sim/mia_host_model.sv]
// apb management host model for the indirect access block
`timescale 1ns/1ps
`default_nettype none
module mia_host_model (
  input  wire logic        pclk,    // clock
  output logic             psel,    // select
  output logic             penable, // enable
  output logic             pwrite,  // direction
  output logic [7:0]       paddr,   // byte address
  output logic [31:0]      pwdata,  // write data
  output logic [3:0]       pstrb,   // byte strobes
  input  wire logic        pready   // ready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one transfer, request held until pready is sampled high or 20 cycles pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released address and data lines do not keep their last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [sim/mia_indirect_access_tb_top.sv]
// self-checking bench for the indirect access block
`timescale 1ns/1ps
`default_nettype none
module mia_indirect_access_tb_top;
  import mia_pkg::*;
  typedef struct packed { logic [31:0] d; logic e; } mia_exp_s;
  localparam logic [7:0] A_CTL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] A_WIN = {IDX_WINDOW[5:0], 2'b00};
  localparam logic [7:0] A_LNK = {IDX_LINK_DROP[5:0], 2'b00};
  logic        pclk;
  logic        presetn;
  logic        pce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [3:0]  pstrb;
  logic [15:0] lfsr_q;
  logic [15:0] v [3][4];
  logic [4:0]  sels [3];
  logic [15:0] bases [3];
  mia_exp_s    cur;
  mia_exp_s    exp_q [$];
  int          num_errors;
  int          num_checks;

  mia_indirect_access i_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mia_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  // response watcher
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("BAD response expected none seen %h", prdata);
      end else begin
        cur = exp_q.pop_front();
        num_checks++;
        if ({prdata, pslverr} !== {cur.d, cur.e}) begin
          num_errors++;
          $display("BAD response expected %h/%b seen %h/%b", cur.d, cur.e, prdata, pslverr);
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [15:0] lfsr();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [31:0] ed, input logic ee);
    logic to;
    exp_q.push_back(mia_exp_s'{ed, ee});
    i_host.xfer(w, a, {16'h0, d}, 4'h3, to);
    if (to) begin
      num_errors++;
      $display("BAD pready expected 1 seen %b", pready);
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0, {16'h0, e}, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    pce = 1'b1;
    lfsr_q = 16'h0040;
    num_errors = 0;
    num_checks = 0;
    sels = '{SEL_VENDOR, SEL_MMD3, SEL_MMD7};
    bases = '{16'h04ce, 16'h07fc, 16'h07fc};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 16'h0000);
    rd(A_WIN, WINDOW_RST);
    wr(A_LNK, 16'hffff);
    rd(A_LNK, 16'h0000);
    acc(1'b1, 8'h40, 16'h1234, 32'h0, 1'b1);
    acc(1'b0, 8'h40, 16'h0000, 32'h0, 1'b1);
    // fill each space from its base, last word at top of range
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, {CMD_ADDRESS, 9'h0, sels[i]});
      wr(A_WIN, bases[i]);
      rd(A_WIN, bases[i]);
      wr(A_CTL, {CMD_INC_RW, 9'h0, sels[i]});
      rd(A_CTL, {CMD_INC_RW, 9'h0, sels[i]});
      for (int k = 0; k < 4; k++) begin
        v[i][k] = lfsr();
        wr(A_WIN, v[i][k]);
      end
      wr(A_CTL, {CMD_DATA, 9'h0, sels[i]});
      rd(A_WIN, 16'h0000);
      wr(A_CTL, {CMD_ADDRESS, 9'h0, sels[i]});
      rd(A_WIN, bases[i] + 16'h4);
      wr(A_WIN, bases[i]);
    end
    // mmd3 and mmd7 share a base, so data proves separation
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, {CMD_DATA, 9'h0, sels[i]});
      rd(A_WIN, v[i][0]);
      rd(A_WIN, v[i][0]);
      wr(A_CTL, {CMD_INC_WR, 9'h0, sels[i]});
      rd(A_WIN, v[i][0]);
      v[i][0] = lfsr();
      wr(A_WIN, v[i][0]);
      rd(A_WIN, v[i][1]);
      wr(A_CTL, {CMD_INC_RW, 9'h0, sels[i]});
      for (int k = 1; k < 4; k++) begin
        rd(A_WIN, v[i][k]);
      end
    end
    // unsupported select leaves every space alone
    wr(A_CTL, {CMD_DATA, 9'h0, 5'h05});
    wr(A_WIN, lfsr());
    rd(A_WIN, 16'h0000);
    wr(A_CTL, {CMD_ADDRESS, 9'h0, 5'h05});
    wr(A_WIN, lfsr());
    rd(A_WIN, 16'h0000);
    wr(A_CTL, {CMD_ADDRESS, 9'h0, SEL_VENDOR});
    rd(A_WIN, 16'h04d2);
    wr(A_WIN, 16'h04ce);
    wr(A_CTL, {CMD_DATA, 9'h0, SEL_VENDOR});
    rd(A_WIN, v[0][0]);
    // clock enable low while idle must keep every register
    pce <= 1'b0;
    repeat (4) @(posedge pclk);
    pce <= 1'b1;
    rd(A_WIN, v[0][0]);
    wr(A_CTL, {CMD_ADDRESS, 9'h0, SEL_MMD3});
    wr(A_WIN, bases[1]);
    wr(A_CTL, {CMD_DATA, 9'h0, SEL_MMD3});
    rd(A_WIN, v[1][0]);
    wr(A_CTL, {CMD_ADDRESS, 9'h0, SEL_MMD7});
    wr(A_WIN, bases[2]);
    wr(A_CTL, {CMD_DATA, 9'h0, SEL_MMD7});
    rd(A_WIN, v[2][0]);
    // reset in mid-run clears control and stored addresses
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 16'h0000);
    wr(A_CTL, {CMD_ADDRESS, 9'h0, SEL_VENDOR});
    rd(A_WIN, WINDOW_RST);
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("BAD pending expected 0 seen %0d", exp_q.size());
    end
    conclude();
  end
endmodule
`default_nettype wire
